// ---- tx_signal_loss_pkg.sv ----
// Purpose: shared constants of the transmit signal-loss monitor
// Assumes: one pulse interval per bit enable strobe
// Notes: amplitude codes and duration counts are plain defaults
`default_nettype none
package tx_signal_loss_pkg;
  // system interface format codes
  localparam logic [1:0] FMT_SINGLE_NRZ = 2'h0;
  localparam logic [1:0] FMT_DUAL_NRZ = 2'h1;
  localparam logic [1:0] FMT_DUAL_RZ = 2'h2;
  // counter and amplitude widths
  localparam int RUN_W = 12;
  localparam int WIN_W = 8;
  localparam int AMP_W = 8;
  // declare thresholds n, in pulse intervals
  localparam logic [11:0] DECL_T1_BASIC = 12'h0af;
  localparam logic [11:0] DECL_T1_LONG = 12'h608;
  localparam logic [11:0] DECL_E1_BASIC = 12'h020;
  localparam logic [11:0] DECL_E1_LONG = 12'h800;
  // clearing window m, in pulse intervals
  localparam logic [7:0] WIN_T1 = 8'haf;
  localparam logic [7:0] WIN_E1 = 8'h20;
  // forbidden zero run inside the clearing window
  localparam logic [7:0] RUN_LIM_T1 = 8'h64;
  localparam logic [7:0] RUN_LIM_E1 = 8'h10;
  // 12.5 percent density is marks times eight against m
  localparam int DENSITY_SHIFT = 3;
  // amplitude thresholds, codes of the amplitude sense
  localparam logic [7:0] AMP_THR_0 = 8'h20;
  localparam logic [7:0] AMP_THR_1 = 8'h40;
  localparam logic [7:0] AMP_THR_2 = 8'h60;
  localparam logic [7:0] AMP_THR_3 = 8'h80;
  // low-amplitude durations, in pulse intervals
  localparam logic [11:0] DUR_0 = 12'h020;
  localparam logic [11:0] DUR_1 = 12'h040;
  localparam logic [11:0] DUR_2 = 12'h080;
  localparam logic [11:0] DUR_3 = 12'h100;
  // system-loss detector states
  typedef enum logic [2:0] {
    ST_OK = 3'b001,
    ST_WAIT = 3'b010,
    ST_WIN = 3'b100
  } sys_state_t;
endpackage
`default_nettype wire

// ---- loss_irq_flag_cell.sv ----
// Purpose: sticky interrupt flag fed by edges of one status bit
// Assumes: clear_i is a one-cycle software clear
// Notes: a set in the clearing cycle wins over the clear
`default_nettype none
module loss_irq_flag_cell
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic status_i,
  input wire logic any_edge_i,
  input wire logic clear_i,
  input wire logic mask_i,
  output logic flag_o,
  output logic request_o
);
  // previous status, for edge detection
  logic prev_q;
  // sticky flag
  logic flag_q;
  logic flag_d;
  // rising or any edge of the status bit
  wire rise = status_i & ~prev_q;
  wire any_edge = status_i ^ prev_q;
  wire hit = any_edge_i ? any_edge : rise;

  // set beats clear
  always_comb
  begin
    flag_d = hit | (flag_q & ~clear_i);
  end

  // edge memory and flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prev_q <= 1'b0;
      flag_q <= 1'b0;
    end
    else
    begin
      prev_q <= status_i;
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;
  // mask high blocks the request
  assign request_o = flag_q & ~mask_i;
endmodule
`default_nettype wire

// ---- tx_signal_loss_monitor.sv ----
// Purpose: per-channel transmit signal-loss monitor, system and line side
// Assumes: bit_en_i pulses once per transmit pulse interval
// Notes: one instance per channel; amplitude comes from an outside sense
//
// What this block does
// - system loss only on dual-rail inputs
// - declare after n consecutive zero intervals
// - clear on 12.5% density window from mark
// - criteria bit picks n per mode
// - t1 window 175, no 100-zero run
// - e1 window 32, no 16-zero run
// - system loss status held while declared
// - flags set on rising or any edge
// - unmasked set flag drives interrupt
// - system loss events feed error counter
// - line loss after low amplitude duration
// - one valid pulse clears line loss
// - line loss status held while declared
// - line loss events feed error counter
// - paired channels judge the shared wire
// - failed driver may miss own status
`default_nettype none
module tx_signal_loss_monitor
#(
  parameter int AMP_WIDTH = tx_signal_loss_pkg::AMP_W
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic bit_en_i,
  input wire logic tx_pos_i,
  input wire logic tx_neg_i,
  input wire logic [1:0] sys_format_i,
  input wire logic e1_mode_i,
  input wire logic loss_criteria_select_i,
  input wire logic [1:0] tx_amplitude_threshold_i,
  input wire logic [1:0] tx_loss_duration_i,
  input wire logic [AMP_WIDTH-1:0] line_amplitude_i,
  input wire logic signal_loss_edge_select_i,
  input wire logic line_out_loss_edge_select_i,
  input wire logic system_loss_irq_mask_i,
  input wire logic line_out_loss_irq_mask_i,
  input wire logic system_loss_irq_clear_i,
  input wire logic line_out_loss_irq_clear_i,
  output logic system_loss_status_o,
  output logic line_out_loss_status_o,
  output logic system_loss_irq_flag_o,
  output logic line_out_loss_irq_flag_o,
  output logic irq_o,
  output logic system_loss_event_o,
  output logic line_out_loss_event_o
);

  // declare threshold from mode and criteria bit
  function automatic logic [11:0] decl_threshold(input logic e1, input logic crit);
    logic [11:0] n;
    n = tx_signal_loss_pkg::DECL_T1_BASIC;
    if (e1)
    begin
      n = crit ? tx_signal_loss_pkg::DECL_E1_LONG : tx_signal_loss_pkg::DECL_E1_BASIC;
    end
    else
    begin
      n = crit ? tx_signal_loss_pkg::DECL_T1_LONG : tx_signal_loss_pkg::DECL_T1_BASIC;
    end
    return n;
  endfunction

  // saturating increment of a run counter
  function automatic logic [11:0] sat_inc(input logic [11:0] v);
    logic [11:0] r;
    r = (v == 12'hfff) ? v : v + 12'h001;
    return r;
  endfunction

  // amplitude threshold from the two-bit field
  function automatic logic [7:0] amp_threshold(input logic [1:0] sel);
    logic [7:0] t;
    case (sel)
      2'h0: t = tx_signal_loss_pkg::AMP_THR_0;
      2'h1: t = tx_signal_loss_pkg::AMP_THR_1;
      2'h2: t = tx_signal_loss_pkg::AMP_THR_2;
      default: t = tx_signal_loss_pkg::AMP_THR_3;
    endcase
    return t;
  endfunction

  // low-amplitude duration from the two-bit field
  function automatic logic [11:0] loss_duration(input logic [1:0] sel);
    logic [11:0] d;
    case (sel)
      2'h0: d = tx_signal_loss_pkg::DUR_0;
      2'h1: d = tx_signal_loss_pkg::DUR_1;
      2'h2: d = tx_signal_loss_pkg::DUR_2;
      default: d = tx_signal_loss_pkg::DUR_3;
    endcase
    return d;
  endfunction

  // system side detector

  // a pulse on either rail is a mark
  wire mark = tx_pos_i | tx_neg_i;
  wire sys_monitor_en = (sys_format_i == tx_signal_loss_pkg::FMT_DUAL_NRZ) |
                        (sys_format_i == tx_signal_loss_pkg::FMT_DUAL_RZ);
  wire [11:0] n_thr = decl_threshold(e1_mode_i, loss_criteria_select_i);
  wire [7:0] m_len = e1_mode_i ? tx_signal_loss_pkg::WIN_E1 : tx_signal_loss_pkg::WIN_T1;
  wire [7:0] run_lim = e1_mode_i ? tx_signal_loss_pkg::RUN_LIM_E1 : tx_signal_loss_pkg::RUN_LIM_T1;

  // consecutive zero intervals
  logic [11:0] zero_run_q;
  logic [11:0] zero_run_d;
  // clearing window: position, marks, current zero run
  logic [7:0] win_cnt_q;
  logic [7:0] win_cnt_d;
  logic [7:0] win_marks_q;
  logic [7:0] win_marks_d;
  logic [7:0] win_run_q;
  logic [7:0] win_run_d;
  // detector state
  tx_signal_loss_pkg::sys_state_t sys_state_q;
  tx_signal_loss_pkg::sys_state_t sys_state_d;
  // system loss status and its event pulse
  logic sys_loss_q;
  logic sys_loss_d;
  logic sys_event_q;

  // zero run after this interval
  assign zero_run_d = mark ? 12'h000 : sat_inc(zero_run_q);
  wire declare_hit = (zero_run_d >= n_thr);

  // window values after this interval
  wire [7:0] win_cnt_nx = win_cnt_q + 8'h01;
  wire [7:0] win_marks_nx = win_marks_q + {7'h00, mark};
  wire [7:0] win_run_nx = mark ? 8'h00 : win_run_q + 8'h01;
  // marks times eight at least m
  wire [10:0] density_scaled = {win_marks_nx, 3'h0};
  wire density_ok = (density_scaled >= {3'h0, m_len});
  // a long zero run spoils the window
  wire run_bad = (win_run_nx >= run_lim);
  wire win_done = (win_cnt_nx == m_len);

  // next state and window bookkeeping
  always_comb
  begin
    sys_state_d = sys_state_q;
    win_cnt_d = win_cnt_q;
    win_marks_d = win_marks_q;
    win_run_d = win_run_q;
    if (!sys_monitor_en)
    begin
      // single rail: detector idle, no loss
      sys_state_d = tx_signal_loss_pkg::ST_OK;
    end
    else if (bit_en_i)
    begin
      case (sys_state_q)
        tx_signal_loss_pkg::ST_OK:
        begin
          if (declare_hit)
          begin
            sys_state_d = tx_signal_loss_pkg::ST_WAIT;
          end
        end
        tx_signal_loss_pkg::ST_WAIT:
        begin
          if (mark)
          begin
            sys_state_d = tx_signal_loss_pkg::ST_WIN;
            win_cnt_d = 8'h01;
            win_marks_d = 8'h01;
            win_run_d = 8'h00;
          end
        end
        tx_signal_loss_pkg::ST_WIN:
        begin
          win_cnt_d = win_cnt_nx;
          win_marks_d = win_marks_nx;
          win_run_d = win_run_nx;
          if (run_bad)
          begin
            sys_state_d = tx_signal_loss_pkg::ST_WAIT;
          end
          else if (win_done)
          begin
            sys_state_d = density_ok ? tx_signal_loss_pkg::ST_OK : tx_signal_loss_pkg::ST_WAIT;
          end
        end
        default:
        begin
          sys_state_d = tx_signal_loss_pkg::ST_OK;
        end
      endcase
    end
  end

  // status high outside the ok state
  assign sys_loss_d = (sys_state_d != tx_signal_loss_pkg::ST_OK);

  // system detector registers
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      sys_state_q <= tx_signal_loss_pkg::ST_OK;
      zero_run_q <= 12'h000;
      win_cnt_q <= 8'h00;
      win_marks_q <= 8'h00;
      win_run_q <= 8'h00;
      sys_loss_q <= 1'b0;
      sys_event_q <= 1'b0;
    end
    else
    begin
      sys_state_q <= sys_state_d;
      win_cnt_q <= win_cnt_d;
      win_marks_q <= win_marks_d;
      win_run_q <= win_run_d;
      sys_loss_q <= sys_loss_d;
      sys_event_q <= sys_loss_d & ~sys_loss_q;
      // zero run only advances per interval
      if (!sys_monitor_en)
      begin
        zero_run_q <= 12'h000;
      end
      else if (bit_en_i)
      begin
        zero_run_q <= zero_run_d;
      end
    end
  end

  // line side detector

  // the sense watches the shared wire, so a
  // high-z pair or failed driver reads as low amplitude
  // own status rests only on the sensed level
  wire [AMP_WIDTH-1:0] amp_thr = AMP_WIDTH'(amp_threshold(tx_amplitude_threshold_i));
  wire [11:0] dur = loss_duration(tx_loss_duration_i);
  wire valid_pulse = (line_amplitude_i > amp_thr);

  // consecutive low-amplitude intervals
  logic [11:0] low_run_q;
  logic [11:0] low_run_d;
  // line loss status and its event pulse
  logic line_loss_q;
  logic line_loss_d;
  logic line_event_q;

  // low run after this interval
  assign low_run_d = valid_pulse ? 12'h000 : sat_inc(low_run_q);

  // line loss decision
  always_comb
  begin
    line_loss_d = line_loss_q;
    if (bit_en_i)
    begin
      if (valid_pulse)
      begin
        line_loss_d = 1'b0;
      end
      else if (low_run_d >= dur)
      begin
        line_loss_d = 1'b1;
      end
    end
  end

  // line detector registers
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      low_run_q <= 12'h000;
      line_loss_q <= 1'b0;
      line_event_q <= 1'b0;
    end
    else
    begin
      if (bit_en_i)
      begin
        low_run_q <= low_run_d;
      end
      line_loss_q <= line_loss_d;
      line_event_q <= line_loss_d & ~line_loss_q;
    end
  end

  // flags and interrupt

  // request of each flag after its mask
  logic sys_req;
  logic line_req;

  // system flag, edge per select bit
  loss_irq_flag_cell sys_flag_cell
  (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .status_i(sys_loss_q),
    .any_edge_i(signal_loss_edge_select_i),
    .clear_i(system_loss_irq_clear_i),
    .mask_i(system_loss_irq_mask_i),
    .flag_o(system_loss_irq_flag_o),
    .request_o(sys_req)
  );

  // line flag, edge per select bit
  loss_irq_flag_cell line_flag_cell
  (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .status_i(line_loss_q),
    .any_edge_i(line_out_loss_edge_select_i),
    .clear_i(line_out_loss_irq_clear_i),
    .mask_i(line_out_loss_irq_mask_i),
    .flag_o(line_out_loss_irq_flag_o),
    .request_o(line_req)
  );

  assign irq_o = sys_req | line_req;

  // status and event outputs from flops
  assign system_loss_status_o = sys_loss_q;
  assign line_out_loss_status_o = line_loss_q;
  assign system_loss_event_o = sys_event_q;
  assign line_out_loss_event_o = line_event_q;

endmodule
`default_nettype wire

// ---- tx_signal_loss_properties.sv ----
// Purpose: concurrent checks on the signal-loss monitor ports
// Assumes: one clock, synchronous active-high reset
// Notes: threshold code n stands for (n+1)*0x20
`default_nettype none
module tx_signal_loss_properties
#(
  parameter int AMP_WIDTH = 8
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic bit_en_i,
  input wire logic [1:0] sys_format_i,
  input wire logic [1:0] tx_amplitude_threshold_i,
  input wire logic [AMP_WIDTH-1:0] line_amplitude_i,
  input wire logic system_loss_irq_mask_i,
  input wire logic line_out_loss_irq_mask_i,
  input wire logic system_loss_status_o,
  input wire logic line_out_loss_status_o,
  input wire logic system_loss_irq_flag_o,
  input wire logic line_out_loss_irq_flag_o,
  input wire logic irq_o,
  input wire logic system_loss_event_o,
  input wire logic line_out_loss_event_o
);
  // amplitude threshold from the two-bit code
  wire logic [2:0] thr_hi = {1'b0, tx_amplitude_threshold_i} + 3'h1;
  wire logic [AMP_WIDTH-1:0] thr = AMP_WIDTH'({thr_hi, 5'h00});
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_irq;
    irq_o == ((system_loss_irq_flag_o & ~system_loss_irq_mask_i)
      | (line_out_loss_irq_flag_o & ~line_out_loss_irq_mask_i));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output wrong");
  property p_sys_off;
    sys_format_i == tx_signal_loss_pkg::FMT_SINGLE_NRZ |=> !system_loss_status_o;
  endproperty
  a_sys_off: assert property (p_sys_off) else $error("system loss on single rail");
  property p_sys_hold;
    system_loss_status_o && !bit_en_i && (sys_format_i[0] ^ sys_format_i[1]) |=> system_loss_status_o;
  endproperty
  a_sys_hold: assert property (p_sys_hold) else $error("system loss dropped idle");
  property p_sys_event;
    $rose(system_loss_status_o) |-> system_loss_event_o ##1 !system_loss_event_o;
  endproperty
  a_sys_event: assert property (p_sys_event) else $error("system event pulse wrong");
  property p_sys_flag;
    $rose(system_loss_status_o) |-> ##[1:2] system_loss_irq_flag_o;
  endproperty
  a_sys_flag: assert property (p_sys_flag) else $error("system flag not set");
  property p_line_clear;
    bit_en_i && line_amplitude_i > thr |=> !line_out_loss_status_o;
  endproperty
  a_line_clear: assert property (p_line_clear) else $error("line loss kept");
  property p_line_hold;
    line_out_loss_status_o && !bit_en_i |=> line_out_loss_status_o;
  endproperty
  a_line_hold: assert property (p_line_hold) else $error("line loss dropped idle");
  property p_line_event;
    line_out_loss_event_o |-> line_out_loss_status_o && !$past(line_out_loss_status_o);
  endproperty
  a_line_event: assert property (p_line_event) else $error("line event stray");
endmodule
`default_nettype wire

// ---- framer_model.sv ----
// Purpose: system framer model, dual-rail data and interval strobe
// Assumes: bench holds run_i, mark_i, lvl_i per interval
// Notes: lines scramble between strobes; slow_i halves the rate
`default_nettype none
module framer_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic slow_i,
  input wire logic mark_i,
  input wire logic [7:0] lvl_i,
  output logic bit_en_o,
  output logic pos_o,
  output logic neg_o,
  output logic [7:0] amp_o
);
  logic ph_q; // slow-mode phase
  logic pol_q; // alternating mark polarity
  wire logic go = run_i & (~slow_i | ph_q); // launch one interval
  // launch, else invert stale lines
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {ph_q, pol_q, bit_en_o, pos_o, neg_o, amp_o} <= '0;
    end
    else
    begin
      ph_q <= ~ph_q;
      bit_en_o <= go;
      pos_o <= go ? mark_i & ~pol_q : ~pos_o;
      neg_o <= go ? mark_i & pol_q : ~neg_o;
      // single driver feeds the sensed level
      amp_o <= go ? lvl_i : ~amp_o;
      pol_q <= pol_q ^ (go & mark_i);
    end
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: self-checking bench of the transmit signal-loss monitor
// Assumes: framer model supplies strobe, data and sensed level
// Notes: intervals go one by one; checks follow an idle gap
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 0, rst_i = 1, run = 0, slow = 0, mark = 0, e1 = 0, crit = 0;
  logic es_s = 0, es_l = 0, mk_s = 0, mk_l = 0, cl_s = 0, cl_l = 0;
  logic [7:0] lvl = 8'hff;
  logic [1:0] fmt = 2'h1, thr = 2'h0, dur = 2'h0;
  logic be, pos, neg, s_st, l_st, s_fl, l_fl, irq;
  logic [7:0] amp;
  int mismatches = 0, checks_done = 0;
  int nd[4] = '{175, 1544, 32, 2048};
  always #50 ref_clk_i = ~ref_clk_i;
  framer_model fm_u (.clk_i(ref_clk_i), .rst_i(rst_i), .run_i(run), .slow_i(slow), .mark_i(mark),
    .lvl_i(lvl), .bit_en_o(be), .pos_o(pos), .neg_o(neg), .amp_o(amp));
  tx_signal_loss_monitor dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bit_en_i(be), .tx_pos_i(pos),
    .tx_neg_i(neg), .sys_format_i(fmt), .e1_mode_i(e1), .loss_criteria_select_i(crit),
    .tx_amplitude_threshold_i(thr), .tx_loss_duration_i(dur), .line_amplitude_i(amp),
    .signal_loss_edge_select_i(es_s), .line_out_loss_edge_select_i(es_l), .system_loss_irq_mask_i(mk_s),
    .line_out_loss_irq_mask_i(mk_l), .system_loss_irq_clear_i(cl_s), .line_out_loss_irq_clear_i(cl_l),
    .system_loss_status_o(s_st), .line_out_loss_status_o(l_st), .system_loss_irq_flag_o(s_fl),
    .line_out_loss_irq_flag_o(l_fl), .irq_o(irq), .system_loss_event_o(), .line_out_loss_event_o());
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge ref_clk_i);
    #1;
  endtask
  // one interval, taken at the launch edge
  task automatic send(input logic m, input logic [7:0] a);
    mark = m;
    lvl = a;
    run = 1;
    do
      tick;
    while (be !== 1'b1);
  endtask
  // n intervals, a mark every per (0 none), then idle
  task automatic burst(input int n, input int per, input logic [7:0] a);
    for (int i = 0; i < n; i++)
      send(per > 0 && i % per == 0, a);
    run = 0;
    repeat (6) tick;
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #(20000 * 100);
    mismatches++;
    end_of_test;
  end
  initial
  begin
    repeat (20) tick;
    rst_i = 0;
    chk(8'({s_st, l_st, s_fl, l_fl, irq}), 8'h00);
    // each mode and criteria: declare, mask, clear
    for (int i = 0; i < 4; i++)
    begin
      e1 = i[1];
      crit = i[0];
      fmt = 2'h1 + 2'(i % 2);
      slow = (i == 2);
      mk_s = 0;
      burst(1, 1, 8'hff);
      burst(nd[i] - 1, 0, 8'hff);
      chk(8'(s_st), 8'h00);
      burst(1, 0, 8'hff);
      chk(8'(s_st), 8'h01);
      chk(8'({s_fl, irq}), 8'h03);
      mk_s = 1;
      tick;
      chk(8'(irq), 8'h00);
      cl_s = 1;
      tick;
      cl_s = 0;
      tick;
      burst((i > 1 ? 32 : 175) - 1, 4, 8'hff);
      chk(8'({s_st, s_fl}), 8'h02);
      burst(1, 0, 8'hff);
      chk(8'({s_st, s_fl}), 8'h00);
    end
    crit = 0;
    burst(32, 0, 8'hff);
    // dense start, then a 28-zero run
    repeat (4) send(1, 8'hff);
    burst(28, 0, 8'hff);
    chk(8'(s_st), 8'h01);
    burst(32, 11, 8'hff);
    chk(8'(s_st), 8'h01);
    // flag cleared while lost, so only the fall can set it
    cl_s = 1;
    tick;
    cl_s = 0;
    chk(8'(s_fl), 8'h00);
    es_s = 1;
    fmt = 2'h0;
    burst(40, 0, 8'hff);
    chk(8'(s_st), 8'h00);
    chk(8'(s_fl), 8'h01);
    // line side: each threshold and duration, rising edge only first
    for (int i = 0; i < 4; i++)
    begin
      thr = 2'(i);
      dur = 2'(i);
      es_l = (i > 0);
      burst((32 << i) - 1, 1, 8'(32 * (i + 1)));
      chk(8'(l_st), 8'h00);
      burst(1, 1, 8'(32 * (i + 1)));
      chk(8'(l_st), 8'h01);
      cl_l = 1;
      tick;
      cl_l = 0;
      burst(1, 1, 8'(32 * (i + 1) + 1));
      chk(8'(l_st), 8'h00);
      chk(8'(l_fl), 8'(i > 0));
    end
    chk(8'({l_fl, irq}), 8'h03);
    mk_l = 1;
    cl_l = 1;
    tick;
    cl_l = 0;
    tick;
    chk(8'({l_fl, irq}), 8'h00);
    end_of_test;
  end
endmodule
bind tx_signal_loss_monitor tx_signal_loss_properties #(.AMP_WIDTH(AMP_WIDTH)) chk_u (.ref_clk_i(ref_clk_i),
  .rst_i(rst_i), .bit_en_i(bit_en_i), .sys_format_i(sys_format_i),
  .tx_amplitude_threshold_i(tx_amplitude_threshold_i), .line_amplitude_i(line_amplitude_i),
  .system_loss_irq_mask_i(system_loss_irq_mask_i), .line_out_loss_irq_mask_i(line_out_loss_irq_mask_i),
  .system_loss_status_o(system_loss_status_o), .line_out_loss_status_o(line_out_loss_status_o),
  .system_loss_irq_flag_o(system_loss_irq_flag_o), .line_out_loss_irq_flag_o(line_out_loss_irq_flag_o),
  .irq_o(irq_o), .system_loss_event_o(system_loss_event_o), .line_out_loss_event_o(line_out_loss_event_o));
`default_nettype wire
